// File: bench/host_port_model.sv
module host_port_model (
  input  wire logic        clk_sys_i,
  output logic             access_o,
  output logic [11:0]      addr_o,
  output logic [2:0]       sel_o,
  output logic [15:0]      wdata_o,
  output logic [1:0]       rate_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    access_o = 1'h0;
    addr_o   = 12'h000;
    sel_o    = 3'h0;
    wdata_o  = 16'h0000;
    rate_o   = 2'h0;
  end
  task automatic xfer(input logic sp, input logic [2:0] sel, input logic [10:0] loc,
                      input logic [15:0] wd, input logic [1:0] rate);
    @(posedge clk_sys_i);
    access_o <= 1'h1;
    addr_o   <= {sp, loc};
    sel_o    <= sel;
    wdata_o  <= wd;
    rate_o   <= rate;
    @(posedge clk_sys_i);
    access_o <= 1'h0;
    // a released bus must not keep showing the last address or write data
    addr_o   <= ~addr_o;
    wdata_o  <= ~wdata_o;
  endtask
endmodule

// File: bench/switch_memory_access_decode_tb.sv
module switch_memory_access_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swmem_pkg::*;
  logic       clk_sys_i, rstn_i, access, reg_acc, dm_acc, cm_acc, valid, cwr;
  logic [11:0] addr;
  logic [2:0]  sel;
  logic [15:0] wdata;
  logic [1:0]  rate;
  mem_loc_t    loc;
  conn_word_t  cword;
  int          num_errors = 0;
  int          checks_done = 0;
  host_port_model host_inst (.clk_sys_i(clk_sys_i), .access_o(access), .addr_o(addr),
    .sel_o(sel), .wdata_o(wdata), .rate_o(rate));
  switch_memory_access_decode switch_memory_access_decode_inst (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .access_i(access), .addr_i(addr), .mem_select_i(sel),
    .wdata_i(wdata), .stream_rate_i(rate), .reg_access_o(reg_acc),
    .data_mem_access_o(dm_acc), .conn_mem_access_o(cm_acc), .loc_o(loc),
    .slot_valid_o(valid), .conn_write_o(cwr), .conn_word_o(cword));
  initial begin
    clk_sys_i = 1'h0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // strobes are {register, data, connection, write}
  task automatic op(input logic sp, input logic [2:0] s, input logic [10:0] l,
                    input logic [15:0] wd, input logic [1:0] r, input logic [3:0] stb,
                    input logic v);
    host_inst.xfer(sp, s, l, wd, r);
    #1;
    chk("strobes", 16'({reg_acc, dm_acc, cm_acc, cwr}), 16'(stb));
    if (sp) chk("loc", 16'(loc), 16'(l));
    if (sp) chk("slot_valid", 16'(valid), 16'(v));
    if (sp && s == 3'h1) chk("word", 16'(cword), 16'({wd[0], wd[11:8], wd[7:1]}));
    @(posedge clk_sys_i);
    #1;
    chk("strobes_idle", 16'({reg_acc, dm_acc, cm_acc, cwr}), 16'h0000);
  endtask
  initial begin
    rstn_i = 1'h0;
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    op(1'h0, 3'h0, 11'h7FF, 16'h0000, 2'h0, 4'h8, 1'h0);
    op(1'h0, 3'h1, 11'h123, 16'h0FFF, 2'h2, 4'h8, 1'h0);
    for (int k = 2; k < 8; k++) begin
      op(1'h1, 3'(k), {4'(k), 7'h00}, 16'h0000, 2'h2, 4'h0, 1'h1);
    end
    op(1'h1, 3'h0, {4'hF, 7'h1F}, 16'h0000, 2'h0, 4'h4, 1'h1);
    op(1'h1, 3'h0, {4'h0, 7'h20}, 16'h0000, 2'h0, 4'h4, 1'h0);
    op(1'h1, 3'h1, {4'h5, 7'h3F}, 16'h0A5F, 2'h1, 4'h3, 1'h1);
    op(1'h1, 3'h1, {4'hA, 7'h40}, 16'h0B80, 2'h1, 4'h3, 1'h0);
    op(1'h1, 3'h1, {4'h3, 7'h7F}, 16'h05FE, 2'h2, 4'h3, 1'h1);
    op(1'h1, 3'h0, {4'h9, 7'h7F}, 16'h0F0F, 2'h3, 4'h4, 1'h1);
    // mid-run reset must clear every held output
    @(posedge clk_sys_i);
    rstn_i <= 1'h0;
    @(posedge clk_sys_i);
    #1;
    chk("reset_strobes", 16'({reg_acc, dm_acc, cm_acc, cwr, valid}), 16'h0000);
    chk("reset_loc", 16'(loc), 16'h0000);
    chk("reset_word", 16'(cword), 16'h0000);
    @(posedge clk_sys_i);
    rstn_i <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    op(1'h1, 3'h1, {4'h7, 7'h11}, 16'h0C23, 2'h0, 4'h3, 1'h1);
    end_of_test();
  end
  initial begin
    #20us;
    num_errors++;
    end_of_test();
  end
endmodule

// File: verilog/channel_range_check.sv
`include "swmem_params.svh"
module channel_range_check (
  input  wire logic [1:0] rate_i,
  input  wire logic [6:0] channel_i,
  output logic            in_range_o
);
  logic [6:0] last;
  always_comb begin
    if (rate_i == `RATE_2M) begin
      last = `LAST_CH_2M;
    end else if (rate_i == `RATE_4M) begin
      last = `LAST_CH_4M;
    end else begin
      last = `LAST_CH_8M;
    end
    in_range_o = (channel_i <= last);
  end
endmodule

// File: verilog/switch_memory_access_decode.sv
`include "swmem_params.svh"
module switch_memory_access_decode
  import swmem_pkg::*;
(
  input  wire logic               clk_sys_i,
  input  wire logic               rstn_i,
  input  wire logic               access_i,
  input  wire logic [11:0]        addr_i,
  input  wire logic [2:0]         mem_select_i,
  input  wire logic [15:0]        wdata_i,
  input  wire logic [1:0]         stream_rate_i,
  output logic                    reg_access_o,
  output logic                    data_mem_access_o,
  output logic                    conn_mem_access_o,
  output mem_loc_t                loc_o,
  output logic                    slot_valid_o,
  output logic                    conn_write_o,
  output conn_word_t              conn_word_o
);
  logic       rst_meta;
  logic       rst_sync;
  logic       in_range;
  logic       space_select_address_bit;
  logic       mem_hit;
  logic       data_hit;
  logic       conn_hit;
  mem_loc_t   next_loc;
  conn_word_t next_word;

  // release is synchronised so every output flop leaves reset on the same edge
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'h0;
      rst_sync <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_sync <= rst_meta;
    end
  end

  assign space_select_address_bit = addr_i[`SPACE_BIT];
  assign mem_hit = access_i && space_select_address_bit;
  assign data_hit = mem_hit && (mem_select_i == `SEL_DATA);
  assign conn_hit = mem_hit && (mem_select_i == `SEL_CONN);

  assign next_loc.stream  = addr_i[`STREAM_HI:`STREAM_LO];
  assign next_loc.channel = addr_i[`CHAN_HI:`CHAN_LO];
  assign next_word.connection_word_mode_bit = wdata_i[`CW_MODE_BIT];
  assign next_word.source_stream_field  = wdata_i[`CW_STREAM_HI:`CW_STREAM_LO];
  assign next_word.source_channel_field = wdata_i[`CW_CHAN_HI:`CW_CHAN_LO];

  channel_range_check channel_range_check_inst (
    .rate_i     (stream_rate_i),
    .channel_i  (next_loc.channel),
    .in_range_o (in_range)
  );

  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      reg_access_o <= 1'h0;
    end else begin
      reg_access_o <= access_i && !space_select_address_bit;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      data_mem_access_o <= 1'h0;
    end else begin
      data_mem_access_o <= data_hit;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      conn_mem_access_o <= 1'h0;
    end else begin
      conn_mem_access_o <= conn_hit;
    end
  end

  // connection write strobe
  // the port carries no read or write line, so every connection access is a write
  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      conn_write_o <= 1'h0;
    end else begin
      conn_write_o <= conn_hit;
    end
  end

  // location capture
  // refused selects still capture, so the last aimed location stays visible
  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      loc_o <= '0;
    end else if (mem_hit) begin
      loc_o <= next_loc;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      slot_valid_o <= 1'h0;
    end else if (mem_hit) begin
      slot_valid_o <= in_range;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync) begin
    if (!rst_sync) begin
      conn_word_o <= '0;
    end else if (mem_hit) begin
      conn_word_o <= next_word;
    end
  end

  chk_reg_space_only: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    reg_access_o |-> !$past(addr_i[`SPACE_BIT]))
    else $error("register access in memory space");

  chk_reg_strobe_set: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    (access_i && !addr_i[`SPACE_BIT]) |=> reg_access_o)
    else $error("register access missed");

  chk_mem_space_route: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    (access_i && addr_i[`SPACE_BIT]) |=> !reg_access_o)
    else $error("memory access hit registers");

  chk_mem_one_target: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    !(data_mem_access_o && conn_mem_access_o))
    else $error("two memories selected");

  chk_data_select: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    (access_i && addr_i[`SPACE_BIT] && mem_select_i == `SEL_DATA) |=> data_mem_access_o)
    else $error("data memory not selected");

  chk_conn_select: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    (access_i && addr_i[`SPACE_BIT] && mem_select_i == `SEL_CONN) |=>
      (conn_mem_access_o && conn_write_o))
    else $error("connection memory not selected");

  chk_refused_select: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    (access_i && mem_select_i != `SEL_DATA && mem_select_i != `SEL_CONN) |=>
      !(data_mem_access_o || conn_mem_access_o))
    else $error("memory strobe on refused select");

  chk_idle_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    !access_i |=> !(reg_access_o || data_mem_access_o || conn_mem_access_o || conn_write_o))
    else $error("strobe without access");

  chk_loc_capture: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    (access_i && addr_i[`SPACE_BIT]) |=> loc_o.channel == $past(addr_i[`CHAN_HI:`CHAN_LO]))
    else $error("channel not captured");

  chk_stream_capture: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    (access_i && addr_i[`SPACE_BIT]) |=>
      loc_o.stream == $past(addr_i[`STREAM_HI:`STREAM_LO]))
    else $error("stream not captured");

  chk_loc_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    !(access_i && addr_i[`SPACE_BIT]) |=>
      ($stable(loc_o) && $stable(slot_valid_o) && $stable(conn_word_o)))
    else $error("location changed without memory access");

  chk_slow_window: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    (access_i && addr_i[`SPACE_BIT] && stream_rate_i == `RATE_2M) |=>
      slot_valid_o == ($past(addr_i[`CHAN_HI:`CHAN_LO]) <= `LAST_CH_2M))
    else $error("2M window");

  chk_mid_window: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    (access_i && addr_i[`SPACE_BIT] && stream_rate_i == `RATE_4M) |=>
      slot_valid_o == ($past(addr_i[`CHAN_HI:`CHAN_LO]) <= `LAST_CH_4M))
    else $error("4M window");

  chk_fast_window: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    (access_i && addr_i[`SPACE_BIT] && stream_rate_i == `RATE_8M) |=> slot_valid_o)
    else $error("8M window");

  chk_out_range: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    (access_i && addr_i[`SPACE_BIT] && stream_rate_i == `RATE_2M &&
      addr_i[`CHAN_HI:`CHAN_LO] > `LAST_CH_2M) |=>
      (!slot_valid_o && loc_o.channel == $past(addr_i[`CHAN_HI:`CHAN_LO])))
    else $error("out of window channel not stored or not flagged");

  chk_mode_capture: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    (access_i && addr_i[`SPACE_BIT]) |=>
      conn_word_o.connection_word_mode_bit == $past(wdata_i[`CW_MODE_BIT]))
    else $error("mode bit not captured");

  chk_word_fields: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    conn_write_o |->
      conn_word_o.source_stream_field == $past(wdata_i[`CW_STREAM_HI:`CW_STREAM_LO]))
    else $error("source stream field");

  chk_chan_field: assert property (@(posedge clk_sys_i) disable iff (!rst_sync)
    conn_write_o |->
      conn_word_o.source_channel_field == $past(wdata_i[`CW_CHAN_HI:`CW_CHAN_LO]))
    else $error("source channel field");
endmodule

// File: verilog/swmem_params.svh
`ifndef SWMEM_PARAMS_SVH
`define SWMEM_PARAMS_SVH
`define ADDR_W          12
`define SPACE_BIT       11
`define STREAM_HI       10
`define STREAM_LO       7
`define CHAN_HI         6
`define CHAN_LO         0
`define SEL_W           3
`define SEL_DATA        3'h0
`define SEL_CONN        3'h1
`define WORD_W          16
`define CW_MODE_BIT     0
`define CW_STREAM_HI    11
`define CW_STREAM_LO    8
`define CW_CHAN_HI      7
`define CW_CHAN_LO      1
`define RATE_2M         2'h0
`define RATE_4M         2'h1
`define RATE_8M         2'h2
`define LAST_CH_2M      7'h1F
`define LAST_CH_4M      7'h3F
`define LAST_CH_8M      7'h7F
`endif

// File: verilog/swmem_pkg.sv
package swmem_pkg;
  typedef struct packed {
    logic [3:0] stream;
    logic [6:0] channel;
  } mem_loc_t;
  typedef struct packed {
    logic       connection_word_mode_bit;
    logic [3:0] source_stream_field;
    logic [6:0] source_channel_field;
  } conn_word_t;
endpackage
